// ===== hbgs_bridge_model.sv
// behavioural half-bridge: gate monitors follow the gate enables after a charge delay
`timescale 1ns/10ps
module hbgs_bridge_model
#(
   parameter int NPH = 3,
   parameter int DLY = 20
)
(
   input wire logic pclk,
   input wire logic [NPH-1:0] gate_hi_on,
   input wire logic [NPH-1:0] gate_lo_on,
   input wire logic [NPH-1:0] stuck_low,
   output logic [NPH-1:0] vgs_hi,
   output logic [NPH-1:0] vgs_lo
);
   // charge delay stays well below the shortest drive window so healthy gates never fault
   logic [NPH-1:0] hi_q [DLY];
   logic [NPH-1:0] lo_q [DLY];
   always_ff @(posedge pclk)
   begin
      hi_q[0] <= gate_hi_on;
      lo_q[0] <= gate_lo_on;
      for (int i = 1; i < DLY; i++)
      begin
         hi_q[i] <= hi_q[i-1];
         lo_q[i] <= lo_q[i-1];
      end
   end
   // a stuck high-side gate never reaches threshold, as an open gate pin would
   assign vgs_hi = hi_q[DLY-1] & ~stuck_low;
   assign vgs_lo = lo_q[DLY-1];
endmodule : hbgs_bridge_model

// ===== hbgs_pkg.sv
// constants and types shared by the half-bridge gate sequencer
package hbgs_pkg;
   // clock period of pclk in picoseconds (250 MHz)
   localparam int CLK_PERIOD_PS = 4000;
   // fixed drive window on strap-configured parts
   localparam int WIN_HW_NS = 4000;
   localparam int WIN_HW_CYC = WIN_HW_NS * 1000 / CLK_PERIOD_PS;
   // selectable drive window and extra dead time, in ns
   localparam int WIN_SEL_NS [4] = '{500, 1000, 2000, 4000};
   localparam int DEAD_SEL_NS [4] = '{0, 50, 100, 200};
   localparam int CNT_W = 10;
   // register word indexes, byte address is index * 4
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_CLEAR = 3'h2;
   localparam logic [2:0] REG_ENABLE = 3'h3;
   localparam logic [2:0] REG_STATE = 3'h4;
   localparam logic [2:0] REG_DRAIN = 3'h5;
   localparam logic [2:0] REG_LAST = 3'h5;
   // control register fields
   localparam int CUR_LSB = 0;
   localparam int WIN_LSB = 4;
   localparam int DEAD_LSB = 6;
   localparam int GAIN_LSB = 8;
   localparam int MODE_LSB = 10;
   localparam logic [11:0] CTRL_RST = 12'h03F;
   localparam logic [2:0] DRAIN_RST = 3'h0;
   // serial frame: read flag, three index bits, twelve data bits
   localparam int FRAME_BITS = 16;
   localparam int HDR_BITS = 4;
   localparam int RW_BIT = 15;
   localparam int IDX_LSB = 12;
   localparam int DATA_W = 12;
   // eight strap levels onto seven steps of the sixteen-step current code
   localparam logic [3:0] CUR_HW_MAP [8] = '{4'h0, 4'h2, 4'h5, 4'h7, 4'hA, 4'hC, 4'hF, 4'hF};
   typedef enum logic [3:0] {
      ST_STEADY = 4'h1,
      ST_OFF = 4'h2,
      ST_DEAD = 4'h4,
      ST_DRIVE = 4'h8
   } hbgs_phase_t;
endpackage : hbgs_pkg

// ===== hbgs_top.sv
// half-bridge gate sequencer: apb registers, serial port, straps, per-phase gate timing machine
// Summary of operation
// RULE_01 - four-wire serial port clocked by serial clock
// RULE_02 - serial transfers only while select_n low
// RULE_03 - serial data out only pulls low
// RULE_04 - strap variant: serial pins become config straps
// RULE_05 - strap variant still reports faults on pin
// RULE_06 - serial variant: sixteen drive current settings
// RULE_07 - strap variant: seven drive current settings
// RULE_08 - drive current for window, then hold
// RULE_09 - turn-on waits for opposite gate off
// RULE_10 - serial variant adds register dead time
// RULE_11 - strong pulldown on opposite gate during window
// RULE_12 - two gate voltage monitors per half-bridge
// RULE_13 - gate fault if threshold missed at window end
// RULE_14 - new command ends the window at once
// RULE_15 - strap window fixed 4 us, else register
// RULE_16 - controller sets window above gate charge time
// RULE_17 - pump undervoltage flagged continuously
// RULE_18 - gate fault latches status, drives fault pin
`timescale 1ns/10ps
module hbgs_top
   import hbgs_pkg::*;
#(
   parameter int NPH = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_variant,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic select_n,
   output logic sdo_o,
   output logic sdo_oe_n,
   input wire logic [1:0] strap_gain,
   input wire logic [2:0] strap_current,
   input wire logic [1:0] strap_mode,
   input wire logic [2:0] drain_threshold_pin,
   input wire logic [NPH-1:0] cmd_hi,
   input wire logic [NPH-1:0] cmd_lo,
   input wire logic [NPH-1:0] vgs_hi,
   input wire logic [NPH-1:0] vgs_lo,
   input wire logic pump_undervoltage,
   output logic [NPH-1:0] gate_hi_on,
   output logic [NPH-1:0] gate_lo_on,
   output logic [NPH-1:0] strong_pd_hi,
   output logic [NPH-1:0] strong_pd_lo,
   output logic [NPH-1:0] drive_active,
   output logic [3:0] gate_current_select,
   output logic [1:0] cfg_gain,
   output logic [1:0] cfg_mode,
   output logic [2:0] cfg_drain,
   output logic fault_out_n,
   output logic irq
);

   localparam int SW = 4 + 4 * NPH;
   localparam int B_SCK = 0;
   localparam int B_SDI = 1;
   localparam int B_SEL = 2;
   localparam int B_PUMP = 3;
   localparam int B_CH = 4;
   localparam int B_CL = 4 + NPH;
   localparam int B_VH = 4 + 2 * NPH;
   localparam int B_VL = 4 + 3 * NPH;

   typedef struct packed {
      logic [SW-1:0] sy0;
      logic [SW-1:0] sy1;
      logic [SW-1:0] sy2;
      logic [SW-1:0] flt;
      logic [SW-1:0] fp;
      logic cap;
      logic hw;
      logic [1:0] s_gain;
      logic [2:0] s_cur;
      logic [1:0] s_mode;
      logic [2:0] s_drain;
      logic [11:0] ctrl;
      logic [2:0] drain;
      logic [NPH:0] stat;
      logic [NPH:0] en;
      logic rdy;
      logic err;
      logic [31:0] rdata;
      logic [15:0] shi;
      logic [4:0] bitc;
      logic [11:0] sho;
      logic oen;
      hbgs_phase_t [NPH-1:0] st;
      logic [NPH-1:0][CNT_W-1:0] cnt;
      logic [NPH-1:0] th;
      logic [NPH-1:0] tl;
      logic [NPH-1:0] gh;
      logic [NPH-1:0] gl;
      logic [NPH-1:0] ph;
      logic [NPH-1:0] pl;
      logic [NPH-1:0] drv;
      logic [3:0] gsel;
      logic [1:0] gain;
      logic [1:0] mode;
      logic [2:0] dthr;
      logic fault_n;
      logic irq;
   } hbgs_state_t;

   hbgs_state_t q;
   hbgs_state_t d;

   logic [CNT_W-1:0] win_cyc;
   logic [CNT_W-1:0] dead_cyc;
   logic [SW-1:0] agree;
   logic acc;
   logic map_ok;
   logic [2:0] bidx;
   logic sck_r;
   logic sck_f;
   logic sel_r;
   logic sel_f;
   logic spi_on;
   logic [31:0] spi_rd;
   logic wr_en;
   logic [2:0] wr_idx;
   logic [11:0] wr_dat;
   logic [NPH:0] clr;
   logic [NPH:0] set;
   logic wh;
   logic wl;
   logic vh;
   logic vl;

   function automatic logic [31:0] rd_reg(input hbgs_state_t s, input logic [2:0] idx);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (idx)
         REG_CTRL: r = 32'(s.ctrl);
         REG_STATUS: r = 32'(s.stat); // RULE_18
         REG_ENABLE: r = 32'(s.en);
         REG_STATE: r = 32'({s.hw, s.drv, s.gl, s.gh});
         REG_DRAIN: r = 32'(s.drain);
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction : rd_reg

   always_comb
   begin
      d = q;
      wr_en = 1'b0;
      wr_idx = REG_CTRL;
      wr_dat = '0;
      clr = '0;
      set = '0;
      wh = 1'b0;
      wl = 1'b0;
      vh = 1'b0;
      vl = 1'b0;
      // three-stage pin synchroniser; a level counts once stages two and three agree
      d.sy0 = {vgs_lo, vgs_hi, cmd_lo, cmd_hi, pump_undervoltage, select_n, sdi, sclk}; // RULE_12
      d.sy1 = q.sy0;
      d.sy2 = q.sy1;
      agree = ~(q.sy1 ^ q.sy2);
      d.flt = (q.flt & ~agree) | (q.sy2 & agree);
      d.fp = q.flt;
      // straps are static, caught once right after reset release
      if (!q.cap)
      begin
         d.cap = 1'b1;
         d.hw = hw_variant;
         d.s_gain = strap_gain; // RULE_04
         d.s_cur = strap_current;
         d.s_mode = strap_mode;
         d.s_drain = drain_threshold_pin;
      end
      // effective configuration
      win_cyc = q.hw ? CNT_W'(WIN_HW_CYC) : CNT_W'(WIN_SEL_NS[q.ctrl[WIN_LSB+:2]] * 1000 / CLK_PERIOD_PS); // RULE_15
      dead_cyc = q.hw ? '0 : CNT_W'((DEAD_SEL_NS[q.ctrl[DEAD_LSB+:2]] * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS); // RULE_10
      d.gsel = q.hw ? CUR_HW_MAP[q.s_cur] : q.ctrl[CUR_LSB+:4]; // RULE_06 RULE_07
      d.gain = q.hw ? q.s_gain : q.ctrl[GAIN_LSB+:2];
      d.mode = q.hw ? q.s_mode : q.ctrl[MODE_LSB+:2];
      d.dthr = q.hw ? q.s_drain : q.drain;
      // apb slave: one wait state, write lands on the completing edge
      acc = psel & penable;
      bidx = paddr[4:2];
      map_ok = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) && (bidx <= REG_LAST);
      d.rdy = 1'b0;
      d.err = 1'b0;
      if (acc && !q.rdy)
      begin
         d.rdy = 1'b1;
         d.err = !map_ok;
         d.rdata = (map_ok && !pwrite) ? rd_reg(q, bidx) : 32'h0000_0000;
      end
      if (acc && q.rdy && pwrite && !q.err)
      begin
         wr_en = 1'b1;
         wr_idx = bidx;
         wr_dat = pwdata[DATA_W-1:0];
      end
      // serial port, mode 1: sample on falling clock, shift out on rising
      sck_r = q.flt[B_SCK] & ~q.fp[B_SCK]; // RULE_01
      sck_f = ~q.flt[B_SCK] & q.fp[B_SCK];
      sel_r = q.flt[B_SEL] & ~q.fp[B_SEL];
      sel_f = ~q.flt[B_SEL] & q.fp[B_SEL];
      spi_on = !q.hw && !q.flt[B_SEL]; // RULE_02 RULE_04
      spi_rd = rd_reg(q, {q.shi[1:0], q.flt[B_SDI]});
      if (!spi_on)
      begin
         d.oen = 1'b1; // RULE_02
      end
      if (spi_on && sel_f)
      begin
         d.bitc = '0;
         d.oen = 1'b1;
      end
      else if (spi_on && sck_f && q.bitc < 5'(FRAME_BITS))
      begin
         d.shi = {q.shi[14:0], q.flt[B_SDI]};
         d.bitc = q.bitc + 5'h01;
         if (q.bitc == 5'(HDR_BITS - 1))
         begin
            d.sho = spi_rd[DATA_W-1:0];
         end
      end
      else if (spi_on && sck_r)
      begin
         if (q.bitc >= 5'(HDR_BITS) && q.bitc < 5'(FRAME_BITS))
         begin
            // open drain: a zero pulls low, a one releases the line
            d.oen = q.sho[DATA_W-1]; // RULE_03
            d.sho = {q.sho[DATA_W-2:0], 1'b0};
         end
         else
         begin
            d.oen = 1'b1;
         end
      end
      // apb wins a same-cycle collision; the serial write is then dropped
      if (!q.hw && sel_r && q.bitc == 5'(FRAME_BITS) && !q.shi[RW_BIT] && !wr_en)
      begin
         wr_en = 1'b1;
         wr_idx = q.shi[IDX_LSB+:3];
         wr_dat = q.shi[DATA_W-1:0];
      end
      if (wr_en)
      begin
         case (wr_idx)
            REG_CTRL: d.ctrl = wr_dat;
            REG_CLEAR: clr = wr_dat[NPH:0];
            REG_ENABLE: d.en = wr_dat[NPH:0];
            REG_DRAIN: d.drain = wr_dat[2:0];
            default: ;
         endcase
      end
      // gate timing machine, one per half-bridge
      for (int i = 0; i < NPH; i++)
      begin
         wh = q.flt[B_CH+i] & ~q.flt[B_CL+i];
         wl = q.flt[B_CL+i] & ~q.flt[B_CH+i];
         vh = q.flt[B_VH+i];
         vl = q.flt[B_VL+i];
         if ({wh, wl} != {q.th[i], q.tl[i]})
         begin
            // a fresh command cuts any running window short
            d.th[i] = wh; // RULE_14
            d.tl[i] = wl;
            d.gh[i] = q.gh[i] & wh;
            d.gl[i] = q.gl[i] & wl;
            d.ph[i] = 1'b0;
            d.pl[i] = 1'b0;
            d.drv[i] = 1'b1; // RULE_08
            d.cnt[i] = '0;
            d.st[i] = ST_OFF;
         end
         else
         begin
            unique case (q.st[i])
               ST_OFF:
               begin
                  d.cnt[i] = q.cnt[i] + 1'b1;
                  if (!q.th[i] && !q.tl[i])
                  begin
                     if (q.cnt[i] == win_cyc - 1'b1)
                     begin
                        set[i] = vh | vl; // RULE_13
                        d.drv[i] = 1'b0;
                        d.st[i] = ST_STEADY;
                     end
                  end
                  else if ((q.th[i] && !vl) || (q.tl[i] && !vh))
                  begin
                     // opposite gate seen off: no fixed delay is trusted
                     d.cnt[i] = '0; // RULE_09
                     d.st[i] = (dead_cyc == '0) ? ST_DRIVE : ST_DEAD;
                     d.gh[i] = (dead_cyc == '0) & q.th[i];
                     d.gl[i] = (dead_cyc == '0) & q.tl[i];
                     d.pl[i] = (dead_cyc == '0) & q.th[i]; // RULE_11
                     d.ph[i] = (dead_cyc == '0) & q.tl[i];
                  end
                  else if (q.cnt[i] == win_cyc - 1'b1)
                  begin
                     set[i] = 1'b1; // RULE_13
                     d.drv[i] = 1'b0;
                     d.st[i] = ST_STEADY;
                  end
               end
               ST_DEAD:
               begin
                  d.cnt[i] = q.cnt[i] + 1'b1;
                  if (q.cnt[i] == dead_cyc - 1'b1)
                  begin
                     d.cnt[i] = '0; // RULE_10
                     d.st[i] = ST_DRIVE;
                     d.gh[i] = q.th[i];
                     d.gl[i] = q.tl[i];
                     d.pl[i] = q.th[i]; // RULE_11
                     d.ph[i] = q.tl[i];
                  end
               end
               ST_DRIVE:
               begin
                  d.cnt[i] = q.cnt[i] + 1'b1;
                  if (q.cnt[i] == win_cyc - 1'b1)
                  begin
                     set[i] = q.th[i] ? (!vh || vl) : (!vl || vh); // RULE_13
                     d.drv[i] = 1'b0; // RULE_08
                     d.ph[i] = 1'b0;
                     d.pl[i] = 1'b0;
                     d.st[i] = ST_STEADY;
                  end
               end
               ST_STEADY: ;
            endcase
         end
      end
      set[NPH] = q.flt[B_PUMP]; // RULE_17
      // set wins over a clear in the same cycle
      d.stat = (q.stat & ~clr) | set; // RULE_18
      d.fault_n = ~|d.stat; // RULE_05
      d.irq = |(d.stat & d.en);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.drain <= DRAIN_RST;
         q.st <= {NPH{ST_STEADY}};
         q.oen <= 1'b1;
         q.fault_n <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.rdy;
   assign pslverr = q.err;
   // the line is only ever pulled low; high comes from the pullup
   assign sdo_o = 1'b0;
   assign sdo_oe_n = q.oen;
   assign gate_hi_on = q.gh;
   assign gate_lo_on = q.gl;
   assign strong_pd_hi = q.ph;
   assign strong_pd_lo = q.pl;
   assign drive_active = q.drv;
   assign gate_current_select = q.gsel;
   assign cfg_gain = q.gain;
   assign cfg_mode = q.mode;
   assign cfg_drain = q.dthr;
   assign fault_out_n = q.fault_n;
   assign irq = q.irq;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_new_cmd;
      ({q.flt[B_CH], q.flt[B_CL]} == 2'b10) && !q.th[0];
   endsequence

   sequence s_turn_on;
      $rose(gate_hi_on[0]);
   endsequence

   a_no_overlap: assert property (!(gate_hi_on[0] && gate_lo_on[0])) // RULE_09
      else $error("both gates of phase 0 on");
   a_turnon_handshake: assert property (s_turn_on |-> $past(q.flt[B_VL]) == 1'b0) // RULE_09
      else $error("high gate turned on while low gate monitor high");
   a_strong_opposite: assert property (s_turn_on |-> strong_pd_lo[0] && drive_active[0]) // RULE_11
      else $error("no strong pulldown on opposite gate at turn-on");
   a_window_bound: assert property (q.st[0] == ST_DRIVE |-> q.cnt[0] < win_cyc) // RULE_15
      else $error("drive window counter passed its length");
   a_preempt_window: assert property (s_new_cmd |=> q.st[0] == ST_OFF && q.cnt[0] == '0) // RULE_14
      else $error("new command did not restart the window");
   a_fault_pin: assert property (q.stat != '0 |-> !fault_out_n) // RULE_18
      else $error("fault pin high with status set");
   a_pump_flag: assert property (q.flt[B_PUMP] |=> q.stat[NPH] ##1 !fault_out_n) // RULE_17
      else $error("pump undervoltage not flagged");
   a_serial_idle: assert property ((q.hw || q.flt[B_SEL]) |=> sdo_oe_n) // RULE_02
      else $error("serial data out driven while deselected");
   a_strap_current: assert property (q.cap && q.hw |=> gate_current_select == CUR_HW_MAP[$past(q.s_cur)]) // RULE_07
      else $error("strap current code not applied");
   a_hold_after: assert property ($fell(drive_active[0]) |-> !strong_pd_lo[0] && !strong_pd_hi[0]) // RULE_08
      else $error("strong pulldown outlived the drive window");

endmodule : hbgs_top

// ===== hbgs_top_tb.sv
// self-checking bench for the half-bridge gate sequencer
`timescale 1ns/10ps
module hbgs_top_tb;
   import hbgs_pkg::*;
   localparam int DLY = 20;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, hw_variant = 0, sclk = 0, sdi = 0, select_n = 1, sdo_o, sdo_oe_n;
   logic [2:0] strap_current = '0, drain_threshold_pin = '0, cmd_hi = '0, cmd_lo = '1, vgs_hi, vgs_lo, stuck = '0;
   logic [2:0] gate_hi_on, gate_lo_on, strong_pd_hi, strong_pd_lo, drive_active, cfg_drain;
   logic [3:0] gate_current_select;
   logic [1:0] cfg_gain, cfg_mode;
   logic pump_undervoltage = 0, fault_out_n, irq;
   int mismatches = 0, total_checks = 0, gap, win;
   always #2 pclk = ~pclk;
   hbgs_top #(.NPH(3)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hw_variant(hw_variant), .sclk(sclk), .sdi(sdi), .select_n(select_n), .sdo_o(sdo_o),
      .sdo_oe_n(sdo_oe_n), .strap_gain(2'h1), .strap_current(strap_current), .strap_mode(2'h0),
      .drain_threshold_pin(drain_threshold_pin), .cmd_hi(cmd_hi), .cmd_lo(cmd_lo), .vgs_hi(vgs_hi),
      .vgs_lo(vgs_lo), .pump_undervoltage(pump_undervoltage), .gate_hi_on(gate_hi_on),
      .gate_lo_on(gate_lo_on), .strong_pd_hi(strong_pd_hi), .strong_pd_lo(strong_pd_lo),
      .drive_active(drive_active), .gate_current_select(gate_current_select), .cfg_gain(cfg_gain),
      .cfg_mode(cfg_mode), .cfg_drain(cfg_drain), .fault_out_n(fault_out_n), .irq(irq));
   hbgs_bridge_model #(.NPH(3), .DLY(DLY)) bridge (.pclk(pclk), .gate_hi_on(gate_hi_on),
      .gate_lo_on(gate_lo_on), .stuck_low(stuck), .vgs_hi(vgs_hi), .vgs_lo(vgs_lo));
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk
   task rng(input int got, input int lo, input int hi, input string m);
      total_checks++;
      if (got < lo || got > hi)
      begin
         mismatches++;
         $display("unexpected at %0t: %s count %0d outside %0d..%0d", $time, m, got, lo, hi);
      end
   endtask : rng
   // every wait is bounded; running out ends the run with a failure
   task tmo(input int n, input int lim);
      if (n >= lim)
      begin
         mismatches++;
         $display("unexpected at %0t: wait timed out", $time);
         stop_test;
      end
   endtask : tmo
   task apb(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
      int n;
      psel <= 1;
      pwrite <= wr;
      paddr <= {3'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      tmo(n, 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   // mode 1 frame: data changes on the rising serial edge, device samples on the falling one
   task spi(input logic sel, input logic [15:0] f);
      select_n <= ~sel;
      repeat (8) @(posedge pclk);
      for (int i = 15; i >= 0; i--)
      begin
         sdi <= f[i];
         sclk <= 1;
         repeat (8) @(posedge pclk);
         sclk <= 0;
         repeat (8) @(posedge pclk);
      end
      select_n <= 1;
      repeat (12) @(posedge pclk);
   endtask : spi
   task idle;
      int n;
      n = 0;
      while (drive_active !== 3'h0 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      tmo(n, 3000);
   endtask : idle
   task sw(input int p, input logic hi);
      int n;
      cmd_hi[p] <= hi;
      cmd_lo[p] <= ~hi;
      n = 0;
      while ((hi ? gate_lo_on[p] : gate_hi_on[p]) !== 1'b0 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      tmo(n, 100);
      gap = 0;
      while ((hi ? gate_hi_on[p] : gate_lo_on[p]) !== 1'b1 && gap < 2000)
      begin
         @(posedge pclk);
         gap++;
      end
      tmo(gap, 2000);
      chk(hi ? strong_pd_lo[p] : strong_pd_hi[p], 1, "opposite pulldown");
      win = 0;
      while (drive_active[p] !== 1'b0 && win < 2000)
      begin
         @(posedge pclk);
         win++;
      end
      tmo(win, 2000);
   endtask : sw
   task rst(input logic hw);
      presetn <= 0;
      hw_variant <= hw;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      repeat (6) @(posedge pclk);
   endtask : rst
   initial
   begin
      @(posedge pclk);
      rst(0);
      apb(0, REG_CTRL, 0);
      chk(rd, 32'h0000003F, "control reset value");
      apb(0, 3'h6, 0);
      chk({rd[30:0], err}, 32'h1, "unmapped access");
      apb(1, REG_CTRL, 32'h00000095);
      // the current code is registered from the stored control word, one edge behind the write
      repeat (2) @(posedge pclk);
      chk(gate_current_select, 4'h5, "current code");
      idle;
      sw(0, 1);
      rng(gap, DLY + 25, DLY + 33, "handshake and extra dead time");
      rng(win, 247, 253, "drive window");
      chk(strong_pd_lo[0], 0, "pulldown after window");
      cmd_hi[2] <= 1;
      cmd_lo[2] <= 0;
      while (gate_hi_on[2] !== 1'b1 && win < 3000)
      begin
         @(posedge pclk);
         win++;
      end
      tmo(win, 3000);
      repeat (30) @(posedge pclk);
      cmd_hi[2] <= 0;
      cmd_lo[2] <= 1;
      repeat (7) @(posedge pclk);
      chk({gate_hi_on[2], strong_pd_lo[2]}, 0, "window cut by new command");
      idle;
      apb(0, REG_STATUS, 0);
      chk(rd, 0, "no fault on healthy bridge");
      stuck[1] <= 1;
      apb(1, REG_ENABLE, 32'h2);
      sw(1, 1);
      repeat (4) @(posedge pclk);
      chk({fault_out_n, irq}, 2'b01, "fault pin and interrupt");
      apb(0, REG_STATUS, 0);
      chk(rd, 32'h2, "gate fault latched");
      apb(1, REG_ENABLE, 0);
      chk(irq, 0, "masked interrupt");
      apb(1, REG_CLEAR, 32'h2);
      stuck[1] <= 0;
      apb(0, REG_STATUS, 0);
      chk({rd[30:0], fault_out_n}, 1, "fault cleared");
      pump_undervoltage <= 1;
      repeat (10) @(posedge pclk);
      pump_undervoltage <= 0;
      apb(0, REG_STATUS, 0);
      chk(rd, 32'h8, "pump undervoltage");
      apb(1, REG_CLEAR, 32'h8);
      spi(0, 16'h009C);
      chk(gate_current_select, 4'h5, "frame without select");
      spi(1, 16'h009A);
      chk(gate_current_select, 4'hA, "serial write");
      chk(sdo_oe_n, 1, "data out released");
      strap_current <= 3'h3;
      drain_threshold_pin <= 3'h5;
      rst(1);
      chk({gate_current_select, 1'b0, cfg_drain}, {4'h7, 4'h5}, "strap decode");
      idle;
      sw(0, 0);
      rng(gap, DLY, DLY + 8, "handshake without extra dead");
      rng(win, 997, 1003, "fixed drive window");
      pump_undervoltage <= 1;
      repeat (10) @(posedge pclk);
      chk(fault_out_n, 0, "fault pin on strap part");
      stop_test;
   end
endmodule : hbgs_top_tb
